// *** verilog/bct_pkg.sv ***
package bct_pkg;
  // opcode patterns
  localparam logic [3:0] BCC_PREFIX = 4'h6;
  localparam logic [9:0] BTI_STATIC_PAT = 10'h021;
  localparam logic [9:0] BTZ_STATIC_PAT = 10'h022;
  localparam logic [3:0] BIT_DYN_PREFIX = 4'h0;
  localparam logic [2:0] BTI_DYN_OPMODE = 3'h5;
  localparam logic [2:0] BTZ_DYN_OPMODE = 3'h6;
  // displacement width selectors in the low opcode byte
  localparam logic [7:0] DISP_WORD_SEL = 8'h00;
  localparam logic [7:0] DISP_LONG_SEL = 8'hff;
  // condition encodings
  localparam logic [3:0] COND_TRUE = 4'h0;
  localparam logic [3:0] COND_SUBR = 4'h1;
  localparam logic [3:0] COND_HI = 4'h2;
  localparam logic [3:0] COND_LS = 4'h3;
  localparam logic [3:0] COND_CC = 4'h4;
  localparam logic [3:0] COND_CS = 4'h5;
  localparam logic [3:0] COND_NE = 4'h6;
  localparam logic [3:0] COND_EQ = 4'h7;
  localparam logic [3:0] COND_VC = 4'h8;
  localparam logic [3:0] COND_VS = 4'h9;
  localparam logic [3:0] COND_PL = 4'ha;
  localparam logic [3:0] COND_MI = 4'hb;
  localparam logic [3:0] COND_GE = 4'hc;
  localparam logic [3:0] COND_LT = 4'hd;
  localparam logic [3:0] COND_GT = 4'he;
  localparam logic [3:0] COND_LE = 4'hf;
  // effective address modes
  localparam logic [2:0] EA_MODE_DREG = 3'h0;
  localparam logic [2:0] EA_MODE_AREG = 3'h1;
  localparam logic [2:0] EA_MODE_EXT = 3'h7;
  localparam logic [2:0] EA_REG_ABS_W = 3'h0;
  localparam logic [2:0] EA_REG_ABS_L = 3'h1;
  // condition flag positions
  localparam int CCR_X = 4;
  localparam int CCR_N = 3;
  localparam int CCR_Z = 2;
  localparam int CCR_V = 1;
  localparam int CCR_C = 0;
  // address arithmetic
  localparam logic [31:0] PC_STEP = 32'h0000_0002;
  localparam logic [31:0] EXT_NONE = 32'h0000_0000;
  localparam logic [31:0] EXT_WORD_BYTES = 32'h0000_0002;
  localparam logic [31:0] EXT_LONG_BYTES = 32'h0000_0004;
  // reset values
  localparam logic [31:0] WORD32_RESET = 32'h0000_0000;
  localparam logic [15:0] WORD16_RESET = 16'h0000;
  localparam logic [4:0] CCR_RESET = 5'h00;
  typedef enum logic [2:0] {
    ST_IDLE, ST_EXT1, ST_EXT2, ST_BITSRC, ST_DREG, ST_MEM_RD, ST_MEM_WR
  } bct_state_type;
endpackage : bct_pkg

// *** verilog/bct_cond_eval.sv ***
`timescale 1ns/10ps
module bct_cond_eval (
  input wire logic [3:0] cond_i, // condition selector
  input wire logic [4:0] ccr_i,  // current flags
  output logic cond_true_o       // selected condition holds
);
  import bct_pkg::*;
  logic n, z, v, c;
  assign n = ccr_i[CCR_N];
  assign z = ccr_i[CCR_Z];
  assign v = ccr_i[CCR_V];
  assign c = ccr_i[CCR_C];
  // evaluate the condition from the flags
  always_comb begin
    case (cond_i)
      COND_TRUE: cond_true_o = 1'b1;
      COND_HI: cond_true_o = ~c & ~z;
      COND_LS: cond_true_o = c | z;
      COND_CC: cond_true_o = ~c;
      COND_CS: cond_true_o = c;
      COND_NE: cond_true_o = ~z;
      COND_EQ: cond_true_o = z;
      COND_VC: cond_true_o = ~v;
      COND_VS: cond_true_o = v;
      COND_PL: cond_true_o = ~n;
      COND_MI: cond_true_o = n;
      COND_GE: cond_true_o = ~(n ^ v);
      COND_LT: cond_true_o = n ^ v;
      COND_GT: cond_true_o = ~(n ^ v) & ~z;
      COND_LE: cond_true_o = z | (n ^ v);
      default: cond_true_o = 1'b0;
    endcase
  end
endmodule : bct_cond_eval

// *** verilog/bct_bit_modify.sv ***
`timescale 1ns/10ps
module bct_bit_modify (
  input wire logic [31:0] operand_i, // destination value
  input wire logic [4:0] bitnum_i,   // raw bit number, low bits
  input wire logic is_long_i,        // register destination
  input wire logic clear_i,          // clear instead of invert
  output logic [31:0] result_o,      // modified value
  output logic zero_o                // tested bit was zero
);
  logic [4:0] idx;
  logic [31:0] mask;
  // bit 0 is the lsb; modulo 32 for registers, modulo 8 for bytes
  assign idx = is_long_i ? bitnum_i : {2'b00, bitnum_i[2:0]};
  assign mask = 32'h0000_0001 << idx;
  assign zero_o = ~operand_i[idx];
  assign result_o = clear_i ? (operand_i & ~mask) : (operand_i ^ mask);
endmodule : bct_bit_modify

// *** verilog/bct_exec.sv ***
`timescale 1ns/10ps
// Summary of operation
// - branch opcode 0110, condition, 8-bit displacement
// - signed byte displacement, taken only if true
// - displacement 00 fetches 16-bit extension word
// - displacement FF fetches 32-bit long displacement
// - branch to next instruction uses word form
// - invert tests bit, sets zero, complements bit
// - clear tests bit, sets zero, clears bit
// - only zero flag written, others unchanged
// - register destination is 32-bit, modulo 32
// - memory destination is byte read-modify-write, modulo 8
// - bit zero is the least significant
// - bit number from immediate word or register
// - static invert form 0000100001 plus ea
// - dynamic invert form register, opmode 101
// - only data alterable destination modes accepted
// - register destination long, memory destination byte
// - target is opcode address plus two plus displacement
// - condition selector uses published encoding
// - dynamic clear form register, opmode 110
module bct_exec (
  input wire logic core_clk_i,             // core clock
  input wire logic reset_i,                // sync reset, active high
  input wire logic instr_valid_i,          // instruction word offered
  input wire logic [15:0] instr_word_i,    // instruction word
  input wire logic [31:0] instr_addr_i,    // address of offered word
  output logic instr_ready_o,              // word accepted when valid
  input wire logic [4:0] ccr_i,            // flags x n z v c
  output logic [2:0] dreg_sel_o,           // data register index
  input wire logic [31:0] dreg_data_i,     // selected register value
  output logic dreg_we_o,                  // write selected register
  output logic [31:0] dreg_wdata_o,        // register write value
  output logic mem_req_o,                  // operand access request
  output logic mem_we_o,                   // access is a byte write
  output logic [2:0] mem_ea_mode_o,        // ea mode of operand
  output logic [2:0] mem_ea_reg_o,         // ea register of operand
  output logic [7:0] mem_wdata_o,          // byte to write
  input wire logic [7:0] mem_rdata_i,      // byte read
  input wire logic mem_ack_i,              // access done
  output logic ccr_we_o,                   // write flags
  output logic [4:0] ccr_o,                // new flags
  output logic pc_load_o,                  // branch resolved
  output logic branch_taken_o,             // condition was true
  output logic [31:0] pc_target_o,         // next program address
  output logic illegal_o,                  // bad destination mode
  output logic unsupported_o               // word not handled here
);
  import bct_pkg::*;

  bct_state_type state, next_state;
  logic [15:0] op_word, next_op_word;
  logic [31:0] op_addr, next_op_addr;
  logic [15:0] disp_hi, next_disp_hi;
  logic [4:0] bitnum, next_bitnum;
  logic next_instr_ready, next_dreg_we, next_mem_req, next_mem_we;
  logic [2:0] next_dreg_sel, next_mem_ea_mode, next_mem_ea_reg;
  logic [31:0] next_dreg_wdata, next_pc_target;
  logic [7:0] next_mem_wdata;
  logic next_ccr_we, next_pc_load, next_branch_taken, next_illegal, next_unsupported;
  logic [4:0] next_ccr;
  logic zero_hold, next_zero_hold;

  // decode of the offered word
  logic take, w_bcc, w_short, w_bti_s, w_btz_s, w_bit_dyn, w_ea_ok;
  assign take = instr_ready_o & instr_valid_i;
  assign w_bcc = instr_word_i[15:12] == BCC_PREFIX;
  assign w_short = instr_word_i[7:0] != DISP_WORD_SEL && instr_word_i[7:0] != DISP_LONG_SEL;
  assign w_bti_s = instr_word_i[15:6] == BTI_STATIC_PAT;
  assign w_btz_s = instr_word_i[15:6] == BTZ_STATIC_PAT;
  assign w_bit_dyn = instr_word_i[15:12] == BIT_DYN_PREFIX &&
                     (instr_word_i[8:6] == BTI_DYN_OPMODE ||
                      instr_word_i[8:6] == BTZ_DYN_OPMODE);
  // data alterable destinations only
  assign w_ea_ok = instr_word_i[5:3] != EA_MODE_AREG &&
                   (instr_word_i[5:3] != EA_MODE_EXT ||
                    instr_word_i[2:0] == EA_REG_ABS_W ||
                    instr_word_i[2:0] == EA_REG_ABS_L);

  // fields of the held opcode
  logic op_clr, op_long_disp;
  assign op_clr = op_word[15:6] == BTZ_STATIC_PAT || op_word[8:6] == BTZ_DYN_OPMODE;
  assign op_long_disp = op_word[7:0] == DISP_LONG_SEL;

  // condition and bit operation units
  logic cond_true, bm_zero;
  logic [3:0] cond_sel;
  logic [31:0] bm_operand, bm_result;
  assign cond_sel = (state == ST_IDLE) ? instr_word_i[11:8] : op_word[11:8];
  assign bm_operand = (state == ST_DREG) ? dreg_data_i : {24'h00_0000, mem_rdata_i};
  bct_cond_eval u_cond (
    .cond_i(cond_sel),
    .ccr_i(ccr_i),
    .cond_true_o(cond_true)
  );
  bct_bit_modify u_bit (
    .operand_i(bm_operand),
    .bitnum_i(bitnum),
    .is_long_i(state == ST_DREG),
    .clear_i(op_clr),
    .result_o(bm_result),
    .zero_o(bm_zero)
  );

  // sequencing and output next values
  logic res_go, go_operand;
  logic [31:0] res_base, res_disp, res_ext;
  always_comb begin
    next_state = state;
    next_op_word = op_word;
    next_op_addr = op_addr;
    next_disp_hi = disp_hi;
    next_bitnum = bitnum;
    next_dreg_sel = dreg_sel_o;
    next_dreg_we = 1'b0;
    next_dreg_wdata = dreg_wdata_o;
    next_mem_req = mem_req_o;
    next_mem_we = mem_we_o;
    next_mem_ea_mode = mem_ea_mode_o;
    next_mem_ea_reg = mem_ea_reg_o;
    next_mem_wdata = mem_wdata_o;
    next_ccr_we = 1'b0;
    next_ccr = ccr_o;
    next_pc_load = 1'b0;
    next_branch_taken = branch_taken_o;
    next_pc_target = pc_target_o;
    next_illegal = 1'b0;
    next_unsupported = 1'b0;
    next_zero_hold = zero_hold;
    res_go = 1'b0;
    go_operand = 1'b0;
    res_base = op_addr;
    res_disp = WORD32_RESET;
    res_ext = EXT_NONE;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_op_word = instr_word_i;
          next_op_addr = instr_addr_i;
          next_mem_ea_mode = instr_word_i[5:3];
          next_mem_ea_reg = instr_word_i[2:0];
          if (w_bcc && instr_word_i[11:8] == COND_SUBR) begin
            next_unsupported = 1'b1;
          end else if (w_bcc && w_short) begin
            res_go = 1'b1;
            res_base = instr_addr_i;
            res_disp = {{24{instr_word_i[7]}}, instr_word_i[7:0]};
          end else if (w_bcc) begin
            next_state = ST_EXT1;
          end else if (w_bti_s || w_btz_s || w_bit_dyn) begin
            if (!w_ea_ok) begin
              next_illegal = 1'b1;
            end else if (w_bit_dyn) begin
              next_dreg_sel = instr_word_i[11:9];
              next_state = ST_BITSRC;
            end else begin
              next_state = ST_EXT1;
            end
          end else begin
            next_unsupported = 1'b1;
          end
        end
      end
      ST_EXT1: begin
        if (take) begin
          if (op_word[15:12] == BCC_PREFIX && op_long_disp) begin
            next_disp_hi = instr_word_i;
            next_state = ST_EXT2;
          end else if (op_word[15:12] == BCC_PREFIX) begin
            res_go = 1'b1;
            res_disp = {{16{instr_word_i[15]}}, instr_word_i};
            res_ext = EXT_WORD_BYTES;
          end else begin
            next_bitnum = instr_word_i[4:0];
            go_operand = 1'b1;
          end
        end
      end
      ST_EXT2: begin
        if (take) begin
          res_go = 1'b1;
          res_disp = {disp_hi, instr_word_i};
          res_ext = EXT_LONG_BYTES;
        end
      end
      ST_BITSRC: begin
        next_bitnum = dreg_data_i[4:0];
        go_operand = 1'b1;
      end
      ST_DREG: begin
        next_dreg_we = 1'b1;
        next_dreg_wdata = bm_result;
        next_ccr_we = 1'b1;
        next_ccr = ccr_i;
        next_ccr[CCR_Z] = bm_zero;
        next_state = ST_IDLE;
      end
      ST_MEM_RD: begin
        if (mem_ack_i) begin
          next_mem_wdata = bm_result[7:0];
          next_zero_hold = bm_zero;
          next_mem_we = 1'b1;
          next_state = ST_MEM_WR;
        end
      end
      ST_MEM_WR: begin
        if (mem_ack_i) begin
          next_mem_req = 1'b0;
          next_mem_we = 1'b0;
          next_ccr_we = 1'b1;
          next_ccr = ccr_i;
          next_ccr[CCR_Z] = zero_hold;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // destination access: register long, memory byte
    if (go_operand) begin
      if (op_word[5:3] == EA_MODE_DREG) begin
        next_dreg_sel = op_word[2:0];
        next_state = ST_DREG;
      end else begin
        next_mem_req = 1'b1;
        next_mem_we = 1'b0;
        next_state = ST_MEM_RD;
      end
    end
    // branch resolution, flags never written here
    if (res_go) begin
      next_pc_load = 1'b1;
      next_branch_taken = cond_true;
      next_pc_target = res_base + PC_STEP + (cond_true ? res_disp : res_ext);
      next_state = ST_IDLE;
    end
    next_instr_ready = next_state == ST_IDLE || next_state == ST_EXT1 ||
                       next_state == ST_EXT2;
  end

  // state and output registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      op_word <= WORD16_RESET;
      op_addr <= WORD32_RESET;
      disp_hi <= WORD16_RESET;
      bitnum <= 5'h00;
      zero_hold <= 1'b0;
      instr_ready_o <= 1'b0;
      dreg_sel_o <= 3'h0;
      dreg_we_o <= 1'b0;
      dreg_wdata_o <= WORD32_RESET;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_ea_mode_o <= 3'h0;
      mem_ea_reg_o <= 3'h0;
      mem_wdata_o <= 8'h00;
      ccr_we_o <= 1'b0;
      ccr_o <= CCR_RESET;
      pc_load_o <= 1'b0;
      branch_taken_o <= 1'b0;
      pc_target_o <= WORD32_RESET;
      illegal_o <= 1'b0;
      unsupported_o <= 1'b0;
    end else begin
      state <= next_state;
      op_word <= next_op_word;
      op_addr <= next_op_addr;
      disp_hi <= next_disp_hi;
      bitnum <= next_bitnum;
      zero_hold <= next_zero_hold;
      instr_ready_o <= next_instr_ready;
      dreg_sel_o <= next_dreg_sel;
      dreg_we_o <= next_dreg_we;
      dreg_wdata_o <= next_dreg_wdata;
      mem_req_o <= next_mem_req;
      mem_we_o <= next_mem_we;
      mem_ea_mode_o <= next_mem_ea_mode;
      mem_ea_reg_o <= next_mem_ea_reg;
      mem_wdata_o <= next_mem_wdata;
      ccr_we_o <= next_ccr_we;
      ccr_o <= next_ccr;
      pc_load_o <= next_pc_load;
      branch_taken_o <= next_branch_taken;
      pc_target_o <= next_pc_target;
      illegal_o <= next_illegal;
      unsupported_o <= next_unsupported;
    end
  end

  // checks on the sequencing
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  chk_short_branch_resolve: assert property (
    state == ST_IDLE && take && w_bcc && w_short && instr_word_i[11:8] != COND_SUBR
    |=> pc_load_o && !ccr_we_o && state == ST_IDLE)
    else $error("short branch not resolved next cycle");
  chk_short_target: assert property (
    state == ST_IDLE && take && w_bcc && w_short && instr_word_i[11:8] != COND_SUBR
    |=> pc_target_o == $past(instr_addr_i) + PC_STEP +
        ($past(cond_true) ? {{24{$past(instr_word_i[7])}}, $past(instr_word_i[7:0])}
                          : EXT_NONE))
    else $error("short branch target wrong");
  chk_word_disp_fetch: assert property (
    state == ST_IDLE && take && w_bcc && instr_word_i[11:8] != COND_SUBR && !w_short
    |=> state == ST_EXT1 && !pc_load_o)
    else $error("zero displacement did not fetch extension");
  chk_long_disp_done: assert property (
    state == ST_EXT2 && take |=> pc_load_o && state == ST_IDLE)
    else $error("long displacement branch not resolved");
  chk_flags_kept: assert property (
    ccr_we_o |-> ccr_o[CCR_X] == $past(ccr_i[CCR_X]) && ccr_o[CCR_N] == $past(ccr_i[CCR_N])
                 && ccr_o[CCR_V] == $past(ccr_i[CCR_V]) && ccr_o[CCR_C] == $past(ccr_i[CCR_C]))
    else $error("flag other than zero changed");
  chk_reg_clear_bit: assert property (
    state == ST_DREG && op_clr |=> dreg_we_o && dreg_wdata_o[$past(bitnum)] == 1'b0
                                   && ccr_o[CCR_Z] == ~$past(dreg_data_i[bitnum]))
    else $error("register clear result or zero flag wrong");
  chk_illegal_dest: assert property (
    state == ST_IDLE && take && (w_bti_s || w_btz_s || w_bit_dyn) && !w_ea_ok
    |=> illegal_o && state == ST_IDLE)
    else $error("illegal destination not flagged");
  chk_mem_write_follows: assert property (
    state == ST_MEM_RD && mem_ack_i |=> mem_req_o && mem_we_o && mem_wdata_o == (op_clr ?
      ($past(mem_rdata_i) & ~(8'h01 << $past(bitnum[2:0]))) :
      ($past(mem_rdata_i) ^ (8'h01 << $past(bitnum[2:0])))))
    else $error("memory byte write wrong");
  chk_no_flags_on_branch: assert property (
    pc_load_o |-> !ccr_we_o && !dreg_we_o && !mem_req_o)
    else $error("branch touched flags or operands");

  cov_short_taken: cover property (pc_load_o && branch_taken_o && state == ST_IDLE);
  cov_long_branch: cover property (state == ST_EXT2 && take);
  cov_mem_bit_op: cover property (state == ST_MEM_WR && mem_ack_i);
  cov_reg_bit_op: cover property (state == ST_DREG);
endmodule : bct_exec

// *** tb/tb.sv ***
`timescale 1ns/10ps
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: %s", $time, m); end end
module tb;
  import bct_pkg::*;
  logic core_clk_i, reset_i, instr_valid_i, mem_ack_i;
  logic [15:0] instr_word_i;
  logic [31:0] instr_addr_i, dreg_data_i, dreg_wdata_o, pc_target_o;
  logic [4:0] ccr_i, ccr_o;
  logic [7:0] mem_rdata_i, mem_wdata_o;
  logic [2:0] dreg_sel_o, mem_ea_mode_o, mem_ea_reg_o;
  logic instr_ready_o, dreg_we_o, mem_req_o, mem_we_o, ccr_we_o;
  logic pc_load_o, branch_taken_o, illegal_o, unsupported_o;
  logic [31:0] regs [8];
  int failures, checks_done;

  // register file seen by the core, read combinationally
  assign dreg_data_i = regs[dreg_sel_o];

  bct_exec i_dut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
    .instr_word_i(instr_word_i), .instr_addr_i(instr_addr_i),
    .instr_ready_o(instr_ready_o), .ccr_i(ccr_i), .dreg_sel_o(dreg_sel_o),
    .dreg_data_i(dreg_data_i), .dreg_we_o(dreg_we_o), .dreg_wdata_o(dreg_wdata_o),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_ea_mode_o(mem_ea_mode_o),
    .mem_ea_reg_o(mem_ea_reg_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .ccr_we_o(ccr_we_o),
    .ccr_o(ccr_o), .pc_load_o(pc_load_o), .branch_taken_o(branch_taken_o),
    .pc_target_o(pc_target_o), .illegal_o(illegal_o), .unsupported_o(unsupported_o)
  );

  // 50 MHz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // inputs change 1 ns after the rising edge
  task automatic tick;
    @(posedge core_clk_i);
    #1;
  endtask : tick

  function automatic logic hit(input int s);
    case (s)
      0: return pc_load_o === 1'b1;
      1: return dreg_we_o === 1'b1;
      2: return ccr_we_o === 1'b1;
      3: return mem_req_o === 1'b1;
      4: return illegal_o === 1'b1;
      5: return unsupported_o === 1'b1;
      default: return (mem_req_o === 1'b1) && (mem_we_o === 1'b1);
    endcase
  endfunction : hit

  // bounded wait for a response pulse or level
  task automatic wait_out(input int s);
    int n;
    n = 0;
    while (!hit(s) && n < 40) begin
      tick();
      n++;
    end
    if (n >= 40) begin
      failures++;
      $display("wrong value at %0t: no response %0d", $time, s);
    end
  endtask : wait_out

  // offer one word and hold it until the edge that takes it
  task automatic send(input logic [15:0] w, input logic [31:0] a);
    int n;
    n = 0;
    instr_valid_i = 1'b1;
    instr_word_i = w;
    instr_addr_i = a;
    while (instr_ready_o !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    if (n >= 40) begin
      failures++;
      $display("wrong value at %0t: word not taken", $time);
    end
    tick();
  endtask : send

  task automatic idle;
    instr_valid_i = 1'b0;
    instr_word_i = ~instr_word_i;
  endtask : idle

  function automatic logic cond_ok(input logic [3:0] c, input logic [4:0] f);
    logic n, z, v, k;
    {n, z, v, k} = f[3:0];
    case (c)
      4'h0: return 1'b1;
      4'h2: return !k && !z;
      4'h3: return k || z;
      4'h4: return !k;
      4'h5: return k;
      4'h6: return !z;
      4'h7: return z;
      4'h8: return !v;
      4'h9: return v;
      4'ha: return !n;
      4'hb: return n;
      4'hc: return n == v;
      4'hd: return n != v;
      4'he: return (n == v) && !z;
      default: return z || (n != v);
    endcase
  endfunction : cond_ok

  // one branch with any displacement form, judged at the resolve pulse
  task automatic branch(input logic [3:0] c, input logic [7:0] d8, input logic [31:0] ext,
                        input logic [4:0] f);
    logic [31:0] a, disp, extb, tgt;
    logic take;
    a = 32'h0000_1000;
    ccr_i = f;
    take = cond_ok(c, f);
    disp = {{24{d8[7]}}, d8};
    extb = EXT_NONE;
    if (d8 == DISP_WORD_SEL) begin
      disp = {{16{ext[15]}}, ext[15:0]};
      extb = EXT_WORD_BYTES;
    end
    if (d8 == DISP_LONG_SEL) begin
      disp = ext;
      extb = EXT_LONG_BYTES;
    end
    tgt = take ? a + PC_STEP + disp : a + PC_STEP + extb;
    send({BCC_PREFIX, c, d8}, a);
    if (d8 == DISP_WORD_SEL) send(ext[15:0], a + 32'h2);
    if (d8 == DISP_LONG_SEL) begin
      send(ext[31:16], a + 32'h2);
      send(ext[15:0], a + 32'h4);
    end
    idle();
    wait_out(0);
    `CHK(branch_taken_o, take, "taken")
    `CHK(pc_target_o, tgt, "target")
    `CHK(ccr_we_o, 1'b0, "flags written")
    tick();
  endtask : branch

  // bit test on register or memory, static or dynamic bit number
  task automatic bitop(input logic clr, input logic dyn, input logic [2:0] m,
                       input logic [2:0] r, input logic [31:0] v, input logic [7:0] bn);
    logic [15:0] op;
    logic [4:0] b;
    logic [31:0] res;
    logic z;
    regs[3] = {24'h5a_5a5a, bn};
    if (m == EA_MODE_DREG) regs[r] = v;
    b = (m == EA_MODE_DREG) ? bn[4:0] : {2'b00, bn[2:0]};
    z = ~v[b];
    res = clr ? v & ~(32'h1 << b) : v ^ (32'h1 << b);
    ccr_i = {2'b10, ~z, 2'b01};
    op = dyn ? {BIT_DYN_PREFIX, 3'h3, clr ? BTZ_DYN_OPMODE : BTI_DYN_OPMODE, m, r}
             : {clr ? BTZ_STATIC_PAT : BTI_STATIC_PAT, m, r};
    send(op, 32'h0000_2000);
    if (!dyn) send({8'h00, bn}, 32'h0000_2002);
    idle();
    `CHK(instr_ready_o, 1'b0, "busy")
    if (m == EA_MODE_DREG) begin
      wait_out(1);
      `CHK(dreg_sel_o, r, "dest reg")
      `CHK(dreg_wdata_o, res, "reg result")
    end else begin
      wait_out(3);
      `CHK({mem_we_o, mem_ea_mode_o, mem_ea_reg_o}, {1'b0, m, r}, "read")
      mem_ack_i = 1'b1;
      mem_rdata_i = v[7:0];
      tick();
      mem_ack_i = 1'b0;
      mem_rdata_i = ~v[7:0];
      tick();
      wait_out(6);
      `CHK(mem_wdata_o, res[7:0], "byte result")
      mem_ack_i = 1'b1;
      tick();
      mem_ack_i = 1'b0;
      wait_out(2);
      `CHK(mem_req_o, 1'b0, "access open")
    end
    `CHK(ccr_we_o, 1'b1, "flag write")
    `CHK(ccr_o, {2'b10, z, 2'b01}, "flags")
    tick();
  endtask : bitop

  task automatic t_branches;
    int c;
    for (c = 0; c < 16; c++) begin
      if (c != 1) begin
        branch(c[3:0], 8'h10, 32'h0, 5'h04);
        branch(c[3:0], 8'hf0, 32'h0, 5'h0b);
      end
    end
    branch(COND_TRUE, 8'h00, 32'h0000_0002, 5'h00);
    branch(COND_EQ, 8'h00, 32'h0000_8000, 5'h04);
    branch(COND_NE, 8'h00, 32'h0000_0100, 5'h04);
    branch(COND_CS, 8'hff, 32'hffff_fff0, 5'h01);
    branch(COND_CC, 8'hff, 32'h0001_0000, 5'h01);
    send({BCC_PREFIX, COND_SUBR, 8'h04}, 32'h0000_1000);
    idle();
    wait_out(5);
    `CHK(unsupported_o, 1'b1, "unsupported")
    tick();
    $display("test branches done");
  endtask : t_branches

  task automatic t_bits;
    int i;
    bitop(1'b0, 1'b1, EA_MODE_DREG, 3'h5, 32'h8000_0001, 8'h3f);
    bitop(1'b1, 1'b1, EA_MODE_DREG, 3'h6, 32'hffff_fffe, 8'h20);
    bitop(1'b0, 1'b0, EA_MODE_DREG, 3'h2, 32'h0000_0000, 8'h23);
    bitop(1'b1, 1'b0, EA_MODE_DREG, 3'h7, 32'hffff_ffff, 8'h1f);
    for (i = 0; i < 7; i++) begin
      bitop(i[0], i[1], (i < 5) ? 3'(i + 2) : EA_MODE_EXT, (i < 5) ? i[2:0] : 3'(i - 5),
            32'h0000_00a5, 8'(8'h0b + i));
    end
    $display("test bit ops done");
  endtask : t_bits

  task automatic t_illegal;
    logic [5:0] ea [4];
    int i;
    ea = '{6'o12, 6'o74, 6'o72, 6'o73};
    for (i = 0; i < 4; i++) begin
      send({BIT_DYN_PREFIX, 3'h3, BTI_DYN_OPMODE, ea[i]}, 32'h0000_3000);
      idle();
      wait_out(4);
      `CHK(illegal_o, 1'b1, "illegal mode")
      tick();
    end
    $display("test illegal done");
  endtask : t_illegal

  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // main sequence
  initial begin
    failures = 0;
    checks_done = 0;
    reset_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_word_i = 16'h0000;
    instr_addr_i = 32'h0000_0000;
    ccr_i = 5'h00;
    mem_ack_i = 1'b0;
    mem_rdata_i = 8'h00;
    for (int k = 0; k < 8; k++) regs[k] = 32'h0000_0000;
    repeat (2) tick();
    reset_i = 1'b0;
    tick();
    t_branches();
    t_bits();
    t_illegal();
    end_sim();
  end

  // watchdog against a hung handshake
  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule : tb
